// *** design/tmr_cfg.svh ***
/*
 * constants of the eight-bit single compare timer: values, codes, masks, resets.
 * assumes inclusion by bare name from the tick, waveform and core design files of the timer.
 */
// Notes on behaviour
// - counter and compare are 8-bit software registers
// - each request has flag bit and mask bit
// - clock select zero stops and holds counter
// - tick from io clock, or crystal when selected
// - 0x00 is bottom, 0xFF is max
// - top is 0xFF or compare, per mode
// - each tick clears, increments or decrements counter
// - counter access works without any tick source
// - software counter write beats clear or count
// - two waveform mode bits pick counting sequence
// - overflow flag set per mode, may interrupt
// - match sets compare flag on next tick
// - compare enable high lets flag interrupt
// - flag cleared by service or one written
// - output from match, mode, output mode bits
// - compare buffered only in pwm modes
// - buffered value loads at top or bottom
// - software compare access hits buffer when buffered
// - force acts like match in normal and clear-on-match modes, no flag, no clear
// - counter write blocks match on next tick
// - mode 0 normal, 2 clear-on-match, 3 fast
// - clear-on-match mode zeroes counter at compare
// - normal wraps 0xFF to 0x00, flags overflow
// - output mode zero does nothing at match
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// counter extremes
`define TMR_BOTTOM   8'h00
`define TMR_MAX      8'hff

// reset values
`define TMR_CNT_RST  8'h00
`define TMR_CMP_RST  8'h00
`define TMR_PRE_RST  10'h000

// compare output mode codes
`define TMR_COM_NONE 2'h0
`define TMR_COM_TGL  2'h1
`define TMR_COM_CLR  2'h2
`define TMR_COM_SET  2'h3

// flag bit positions in interrupt_flag_reg
`define TMR_FLAG_OVF 0
`define TMR_FLAG_CMP 1

// prescaler masks: divisor minus one
`define TMR_DIV1     10'h000
`define TMR_DIV8     10'h007
`define TMR_DIV32    10'h01f
`define TMR_DIV64    10'h03f
`define TMR_DIV128   10'h07f
`define TMR_DIV256   10'h0ff
`define TMR_DIV1024  10'h3ff

`endif

// *** design/tmr_pkg.sv ***
/*
 * types shared by the timer modules.
 * assumes nothing of its surroundings.
 */
package tmr_pkg;
	// waveform_mode_field codes in order 0..3
	typedef enum logic [1:0] {
		TMR_NORMAL,
		TMR_PHASE,
		TMR_CTC,
		TMR_FAST
	} tmr_mode_e;
endpackage

// *** design/tmr_cnt_if.sv ***
/*
 * internal carrier between the timer core, its tick source and its waveform logic.
 * assumes all three sit on the one clock and reset.
 */
`timescale 1ns/1ps
`default_nettype none
interface tmr_cnt_if (
	input wire logic clk,
	input wire logic rst
);
	logic              tick;       // one-cycle timer tick
	logic [2:0]        cs;         // clock_select_field
	logic              async_sel;  // async_clock_select
	logic              xtal_rise;  // synced crystal edge
	tmr_pkg::tmr_mode_e mode;      // active waveform mode
	logic [1:0]        com;        // compare_output_mode
	logic              match_evt;  // unblocked match on a tick
	logic              bottom_evt; // tick landing on bottom in fast mode
	logic              dir_down;   // phase mode downslope
	logic              force_cmp;  // force strobe
	logic              oc_q;       // current compare output
	logic              oc_d;       // next compare output

	modport tick_src (input clk, rst, cs, async_sel, xtal_rise, output tick);
	modport wave (input clk, rst, mode, com, match_evt, bottom_evt, dir_down,
		force_cmp, oc_q, output oc_d);
endinterface
`default_nettype wire

// *** design/tmr_tick_gen.sv ***
/*
 * timer tick source: ten-bit prescaler fed by io clock or crystal edges.
 * assumes xtal_rise is already synchronised and one cycle wide.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tmr_cfg.svh"
module tmr_tick_gen (
	// carrier
	tmr_cnt_if.tick_src t
);
	logic [9:0] pre_q;  // prescaler count
	logic [9:0] pre_d;  // next count
	logic [9:0] mask;   // selected divisor mask
	logic       src;    // source event this cycle

	// divisor pick and tick decode
	always_comb
	begin
		src = t.async_sel ? t.xtal_rise : 1'b1;
		unique case (t.cs)
			3'h1: mask = `TMR_DIV1;
			3'h2: mask = `TMR_DIV8;
			3'h3: mask = `TMR_DIV32;
			3'h4: mask = `TMR_DIV64;
			3'h5: mask = `TMR_DIV128;
			3'h6: mask = `TMR_DIV256;
			3'h7: mask = `TMR_DIV1024;
			3'h0: mask = `TMR_DIV1;
		endcase
		// zero select gives no tick at all
		t.tick = (t.cs != 3'h0) && src && ((pre_q & mask) == mask);
		pre_d = src ? pre_q + 10'h001 : pre_q;
	end

	// prescaler free-runs so taps stay aligned across selects
	always_ff @(posedge t.clk)
	begin
		if (t.rst)
			pre_q <= `TMR_PRE_RST;
		else
			pre_q <= pre_d;
	end

	a_stop_no_tick: assert property (@(posedge t.clk) disable iff (t.rst)
		(t.cs == 3'h0) |-> !t.tick)
		else $error("tick while clock select is zero");
endmodule
`default_nettype wire

// *** design/tmr_wave_gen.sv ***
/*
 * waveform generator: next compare output from match, bottom, mode and output mode.
 * assumes the core registers oc_d into oc_q every cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tmr_cfg.svh"
module tmr_wave_gen (
	// carrier
	tmr_cnt_if.wave w
);
	logic nonpwm; // normal or clear-on-match

	// next output value
	always_comb
	begin
		nonpwm = (w.mode == tmr_pkg::TMR_NORMAL) || (w.mode == tmr_pkg::TMR_CTC);
		w.oc_d = w.oc_q;
		unique case (w.mode)
			tmr_pkg::TMR_NORMAL, tmr_pkg::TMR_CTC:
			begin
				// forced strobe acts as a match here only
				if (w.match_evt || w.force_cmp)
				begin
					unique case (w.com)
						`TMR_COM_TGL: w.oc_d = ~w.oc_q;
						`TMR_COM_CLR: w.oc_d = 1'b0;
						`TMR_COM_SET: w.oc_d = 1'b1;
						`TMR_COM_NONE: w.oc_d = w.oc_q;
					endcase
				end
			end
			tmr_pkg::TMR_FAST:
			begin
				// match wins if it lands on bottom together
				if (w.match_evt && w.com[1])
					w.oc_d = w.com[0];
				else if (w.bottom_evt && w.com[1])
					w.oc_d = ~w.com[0];
			end
			tmr_pkg::TMR_PHASE:
			begin
				// upslope clears for non-inverting, downslope sets
				if (w.match_evt && w.com[1])
					w.oc_d = w.com[0] ^ w.dir_down;
			end
		endcase
	end

	a_mode_zero_idle: assert property (@(posedge w.clk) disable iff (w.rst)
		(w.com == `TMR_COM_NONE) |-> (w.oc_d == w.oc_q))
		else $error("output moved with output mode zero");
	a_force_toggles: assert property (@(posedge w.clk) disable iff (w.rst)
		(w.force_cmp && nonpwm && !w.match_evt && w.com == `TMR_COM_TGL)
		|-> (w.oc_d != w.oc_q))
		else $error("force did not toggle output");
endmodule
`default_nettype wire

// *** design/tmr_core.sv ***
/*
 * eight-bit timer/counter with one compare unit: counter, compare buffer,
 * flags, interrupt requests and compare output.
 * assumes software strobes are one clk wide and synchronous to clk;
 * crystal_pin_in is asynchronous and is synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tmr_cfg.svh"
module tmr_core #(
	parameter int W = 8 // counter width
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// counter access
	input  wire logic         cnt_wr,
	input  wire logic [W-1:0] cnt_wdata,
	output logic [W-1:0]      counter_value,
	// compare access
	input  wire logic         cmp_wr,
	input  wire logic [W-1:0] cmp_wdata,
	output logic [W-1:0]      compare_value,
	// timer_control_a and clock fields
	input  wire logic [1:0]   waveform_mode_field,
	input  wire logic [1:0]   compare_output_mode,
	input  wire logic [2:0]   clock_select_field,
	input  wire logic         async_clock_select,
	input  wire logic         force_compare,
	// interrupt_mask_reg bits
	input  wire logic         overflow_irq_enable,
	input  wire logic         compare_irq_enable,
	// interrupt_flag_reg clear and service
	input  wire logic         flag_clear_wr,
	input  wire logic [1:0]   flag_clear_data,
	input  wire logic         overflow_irq_ack,
	input  wire logic         compare_irq_ack,
	// status and requests
	output logic [1:0]        interrupt_flag_reg,
	output logic              overflow_irq,
	output logic              compare_irq,
	// pins
	input  wire logic         crystal_pin_in,
	output logic              crystal_pin_out,
	output logic              compare_output
);
	tmr_cnt_if c (.clk(clk), .rst(rst));

	logic [W-1:0] cnt_q, cnt_d;       // counter
	logic [W-1:0] ocr_q, ocr_d;       // active compare
	logic [W-1:0] buf_q, buf_d;       // compare buffer
	logic [W-1:0] cmp_rd_q, cmp_rd_d; // compare readback
	logic         dir_q, dir_d;       // phase mode going down
	logic         blk_q, blk_d;       // match blocked after write
	logic         ovf_q, ovf_d;       // overflow flag
	logic         cf_q, cf_d;         // compare flag
	logic         oirq_q, cirq_q;     // request outputs
	logic         oc_q;               // compare output
	logic [2:0]   xs_q;               // crystal sync chain
	logic         xo_q;               // crystal feedback drive
	logic         pwm;                // buffered modes
	logic         match;              // comparator equality
	logic         top_hit;            // counter at top
	logic         ovf_set, cf_set;    // flag set events
	logic         load;               // buffer to active transfer
	logic [W-1:0] max_v, bot_v;       // extremes at width

	assign max_v = W'(`TMR_MAX);
	assign bot_v = W'(`TMR_BOTTOM);

	// carrier hookup
	assign c.cs        = clock_select_field;
	assign c.async_sel = async_clock_select;
	assign c.xtal_rise = xs_q[1] & ~xs_q[2];
	assign c.mode      = tmr_pkg::tmr_mode_e'(waveform_mode_field);
	assign c.com       = compare_output_mode;
	assign c.dir_down  = dir_q;
	assign c.force_cmp = force_compare & ~pwm;
	assign c.oc_q      = oc_q;

	// tick source and waveform logic share the carrier
	tmr_tick_gen u_tick (
		.t (c.tick_src)
	);

	tmr_wave_gen u_wave (
		.w (c.wave)
	);

	// crystal pin sync; xs_q[0] feeds only xs_q[1]
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			xs_q <= 3'h0;
			xo_q <= 1'b0;
		end
		else
		begin
			xs_q <= {xs_q[1:0], crystal_pin_in};
			xo_q <= ~xs_q[1]; // inverting feedback for the crystal
		end
	end

	// counter, direction and block: next values
	always_comb
	begin
		pwm     = (c.mode == tmr_pkg::TMR_FAST) || (c.mode == tmr_pkg::TMR_PHASE);
		match   = (cnt_q == ocr_q);
		// top is compare in clear-on-match mode, else max
		top_hit = (c.mode == tmr_pkg::TMR_CTC) ? match : (cnt_q == max_v);
		cnt_d   = cnt_q;
		dir_d   = dir_q;
		ovf_set = 1'b0;
		if (c.tick)
		begin
			unique case (c.mode)
				tmr_pkg::TMR_NORMAL, tmr_pkg::TMR_FAST:
				begin
					cnt_d = cnt_q + W'(1); // wraps max to bottom
					ovf_set = (cnt_q == max_v);
				end
				tmr_pkg::TMR_CTC:
				begin
					cnt_d = top_hit ? bot_v : cnt_q + W'(1);
					ovf_set = (cnt_q == max_v);
				end
				tmr_pkg::TMR_PHASE:
				begin
					if (!dir_q && cnt_q == max_v)
					begin
						cnt_d = cnt_q - W'(1);
						dir_d = 1'b1;
					end
					else if (dir_q && cnt_q == bot_v)
					begin
						cnt_d = cnt_q + W'(1);
						dir_d = 1'b0;
						ovf_set = 1'b1;
					end
					else
						cnt_d = dir_q ? cnt_q - W'(1) : cnt_q + W'(1);
				end
			endcase
		end
		// direction only matters in phase mode; park it low elsewhere
		if (c.mode != tmr_pkg::TMR_PHASE)
			dir_d = 1'b0;
		// block lasts until the tick after a write, stopped or not
		blk_d = cnt_wr ? 1'b1 : (c.tick ? 1'b0 : blk_q);
		if (cnt_wr)
			cnt_d = cnt_wdata;
	end

	// match and bottom events, each only on a tick
	assign c.match_evt  = c.tick & match & ~blk_q;
	assign c.bottom_evt = c.tick & (cnt_q == max_v) & (c.mode == tmr_pkg::TMR_FAST);

	// counter registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_q <= `TMR_CNT_RST;
			dir_q <= 1'b0;
			blk_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			dir_q <= dir_d;
			blk_q <= blk_d;
		end
	end

	// compare active, buffer and readback: next values
	always_comb
	begin
		// fast loads at bottom, phase at top
		load = pwm && c.tick && (cnt_q == max_v) &&
			((c.mode == tmr_pkg::TMR_FAST) || !dir_q);
		buf_d = cmp_wr ? cmp_wdata : buf_q;
		ocr_d = ocr_q;
		if (!pwm && cmp_wr)
			ocr_d = cmp_wdata;
		else if (load)
			ocr_d = buf_q;
		cmp_rd_d = pwm ? buf_d : ocr_d;
	end

	// compare registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ocr_q    <= `TMR_CMP_RST;
			buf_q    <= `TMR_CMP_RST;
			cmp_rd_q <= `TMR_CMP_RST;
		end
		else
		begin
			ocr_q    <= ocr_d;
			buf_q    <= buf_d;
			cmp_rd_q <= cmp_rd_d;
		end
	end

	// flags: a set in the clearing cycle wins
	// clears come from acks and write-one strobes
	always_comb
	begin
		cf_set = c.match_evt;
		ovf_d = ovf_q;
		cf_d  = cf_q;
		if (overflow_irq_ack || (flag_clear_wr && flag_clear_data[`TMR_FLAG_OVF]))
			ovf_d = 1'b0;
		if (compare_irq_ack || (flag_clear_wr && flag_clear_data[`TMR_FLAG_CMP]))
			cf_d = 1'b0;
		if (ovf_set)
			ovf_d = 1'b1;
		if (cf_set)
			cf_d = 1'b1;
	end

	// flag, request and output registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ovf_q  <= 1'b0;
			cf_q   <= 1'b0;
			oirq_q <= 1'b0;
			cirq_q <= 1'b0;
			oc_q   <= 1'b0;
		end
		else
		begin
			ovf_q  <= ovf_d;
			cf_q   <= cf_d;
			oirq_q <= ovf_q & overflow_irq_enable;
			cirq_q <= cf_q & compare_irq_enable;
			oc_q   <= c.oc_d;
		end
	end

	assign counter_value      = cnt_q;
	assign compare_value      = cmp_rd_q;
	assign interrupt_flag_reg = {cf_q, ovf_q};
	assign overflow_irq       = oirq_q;
	assign compare_irq        = cirq_q;
	assign compare_output     = oc_q;
	assign crystal_pin_out    = xo_q;

	// all checks below run on clk and pause in reset
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_stop_holds: assert property (
		(clock_select_field == 3'h0 && !cnt_wr) |=> (cnt_q == $past(cnt_q)))
		else $error("counter moved while stopped");
	a_write_wins: assert property (
		cnt_wr |=> (cnt_q == $past(cnt_wdata)))
		else $error("counter write lost");
	a_normal_wrap: assert property (
		(c.tick && c.mode == tmr_pkg::TMR_NORMAL && cnt_q == max_v && !cnt_wr)
		|=> (cnt_q == bot_v) && ovf_q)
		else $error("normal wrap without overflow");
	a_ctc_clear: assert property (
		(c.tick && c.mode == tmr_pkg::TMR_CTC && match && !cnt_wr) |=> (cnt_q == bot_v))
		else $error("clear-on-match did not zero counter");
	a_match_flag: assert property (
		(c.tick && match && !blk_q) |=> cf_q)
		else $error("match did not set compare flag");
	a_write_blocks: assert property (
		(cnt_wr ##1 (c.tick && !compare_irq_ack && !flag_clear_wr && !cnt_wr))
		|=> (cf_q == $past(cf_q)))
		else $error("match after counter write not blocked");
	a_set_beats_clear: assert property (
		(c.match_evt && flag_clear_wr && flag_clear_data[`TMR_FLAG_CMP]) |=> cf_q)
		else $error("flag clear beat a set");
	a_irq_gate: assert property (
		cf_q && compare_irq_enable |=> compare_irq)
		else $error("enabled compare flag gave no request");
	a_buffer_hold: assert property (
		(pwm && !c.tick) |=> $stable(ocr_q))
		else $error("buffered compare changed off top or bottom");

	// turnaround, direct writes, force and overflow requests
	a_direct_write: assert property (
		(!pwm && cmp_wr) |=> (ocr_q == $past(cmp_wdata)))
		else $error("unbuffered compare write missed");
	a_phase_turn: assert property (
		(c.tick && c.mode == tmr_pkg::TMR_PHASE && !dir_q && cnt_q == max_v && !cnt_wr)
		|=> (dir_q && (cnt_q == max_v - W'(1))))
		else $error("phase mode did not turn down at max");
	a_phase_load: assert property (
		(c.tick && c.mode == tmr_pkg::TMR_PHASE && !dir_q && cnt_q == max_v)
		|=> (ocr_q == $past(buf_q)))
		else $error("phase top did not load compare");
	a_force_no_flag: assert property (
		(force_compare && !c.match_evt && !cf_q) |=> !cf_q)
		else $error("force set the compare flag");
	a_ovf_request: assert property (
		(ovf_q && overflow_irq_enable) |=> overflow_irq)
		else $error("enabled overflow flag gave no request");
endmodule
`default_nettype wire

// *** verification/tmr_core_tb.sv ***
/*
 * self-checking bench of the eight-bit single compare timer core.
 * assumes the design sources are compiled first; drives at falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
module timer8_single_compare_core_tb_top;
	// clock and reset
	logic       clk = 1'b0;
	logic       rst;
	// software strobes and data
	logic       cnt_wr;
	logic [7:0] cnt_wdata;
	logic       cmp_wr;
	logic [7:0] cmp_wdata;
	logic       flag_clear_wr;
	logic [1:0] flag_clear_data;
	logic       force_compare;
	logic       overflow_irq_ack;
	logic       compare_irq_ack;
	// control levels
	logic [1:0] waveform_mode_field;
	logic [1:0] compare_output_mode;
	logic [2:0] clock_select_field;
	logic       async_clock_select;
	logic       overflow_irq_enable;
	logic       compare_irq_enable;
	logic       crystal_pin_in;
	// design outputs
	logic [7:0] counter_value;
	logic [7:0] compare_value;
	logic [1:0] interrupt_flag_reg;
	logic       overflow_irq;
	logic       compare_irq;
	logic       crystal_pin_out;
	logic       compare_output;
	// tallies
	int         miscompares;
	int         checks;

	tmr_core i_tmr_core (.clk, .rst, .cnt_wr, .cnt_wdata, .counter_value, .cmp_wr,
		.cmp_wdata, .compare_value, .waveform_mode_field, .compare_output_mode,
		.clock_select_field, .async_clock_select, .force_compare, .overflow_irq_enable,
		.compare_irq_enable, .flag_clear_wr, .flag_clear_data, .overflow_irq_ack,
		.compare_irq_ack, .interrupt_flag_reg, .overflow_irq, .compare_irq,
		.crystal_pin_in, .crystal_pin_out, .compare_output);

	// free running clock, 4 ns
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// one compare for every value, bits zero extended
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask

	// verdict and end of run
	task automatic results();
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic tk(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wcnt(input logic [7:0] v);
		cnt_wdata = v;
		cnt_wr = 1'b1;
		tk(1);
		cnt_wr = 1'b0;
	endtask

	task automatic wcmp(input logic [7:0] v);
		cmp_wdata = v;
		cmp_wr = 1'b1;
		tk(1);
		cmp_wr = 1'b0;
	endtask

	// write-one clear, then let it land
	task automatic clr(input logic [1:0] m);
		flag_clear_data = m;
		flag_clear_wr = 1'b1;
		tk(1);
		flag_clear_wr = 1'b0;
		tk(1);
	endtask

	// bounded wait: a miss ends the run
	task automatic waitc(input logic [7:0] v);
		int i;
		for (i = 0; i < 600 && counter_value !== v; i++)
			tk(1);
		if (i == 600)
		begin
			miscompares++;
			results();
		end
	endtask

	// wrap, overflow request, ack, write priority, stop
	task automatic t_normal();
		waveform_mode_field = 2'h0;
		overflow_irq_enable = 1'b1;
		clock_select_field = 3'h1;
		wcnt(8'hfd);
		waitc(8'h00);
		chk("ovf flag", 8'h01, {7'h0, interrupt_flag_reg[0]});
		tk(1);
		chk("ovf irq", 8'h01, {7'h0, overflow_irq});
		overflow_irq_ack = 1'b1;
		tk(1);
		overflow_irq_ack = 1'b0;
		tk(1);
		chk("ovf ack", 8'h00, {7'h0, interrupt_flag_reg[0]});
		wcnt(8'h80);
		chk("wr prio", 8'h80, counter_value);
		clock_select_field = 3'h0;
		tk(5);
		chk("stopped", 8'h80, counter_value);
		wcnt(8'h42);
		chk("wr stop", 8'h42, counter_value);
	endtask

	// match flag, its request, both ways of clearing
	task automatic t_compare();
		compare_irq_enable = 1'b1;
		wcmp(8'h10);
		chk("cmp rd", 8'h10, compare_value);
		wcnt(8'h0c);
		clr(2'h3);
		clock_select_field = 3'h1;
		waitc(8'h11);
		chk("cmp flag", 8'h01, {7'h0, interrupt_flag_reg[1]});
		tk(1);
		chk("cmp irq", 8'h01, {7'h0, compare_irq});
		clr(2'h2);
		chk("cmp w1c", 8'h00, {7'h0, interrupt_flag_reg[1]});
		waitc(8'h11);
		compare_irq_ack = 1'b1;
		tk(1);
		compare_irq_ack = 1'b0;
		tk(1);
		chk("cmp ack", 8'h00, {7'h0, interrupt_flag_reg[1]});
		clock_select_field = 3'h0;
	endtask

	// write equal to compare while stopped, match must vanish
	task automatic t_block();
		wcmp(8'h20);
		wcnt(8'h20);
		clr(2'h3);
		clock_select_field = 3'h1;
		tk(4);
		chk("blocked", 8'h00, {7'h0, interrupt_flag_reg[1]});
		clock_select_field = 3'h0;
	endtask

	// clear-on-match with toggling output
	task automatic t_ctc();
		logic o;
		waveform_mode_field = 2'h2;
		compare_output_mode = 2'h1;
		wcmp(8'h05);
		wcnt(8'h00);
		clr(2'h3);
		o = compare_output;
		clock_select_field = 3'h1;
		waitc(8'h05);
		tk(1);
		chk("ctc clr", 8'h00, counter_value);
		chk("ctc flag", 8'h01, {7'h0, interrupt_flag_reg[1]});
		tk(1);
		chk("ctc out", {7'h0, ~o}, {7'h0, compare_output});
		clock_select_field = 3'h0;
	endtask

	// forced match through every output mode code
	task automatic t_force();
		logic [1:0] fc [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
		logic       fe [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
		logic [7:0] v;
		waveform_mode_field = 2'h0;
		wcmp(8'h77);
		clr(2'h3);
		v = counter_value;
		for (int i = 0; i < 5; i++)
		begin
			compare_output_mode = fc[i];
			force_compare = 1'b1;
			tk(1);
			force_compare = 1'b0;
			tk(2);
			chk("force out", {7'h0, fe[i]}, {7'h0, compare_output});
		end
		chk("force flag", 8'h00, {6'h0, interrupt_flag_reg});
		chk("force cnt", v, counter_value);
		// ignored in pwm: a set would show
		waveform_mode_field = 2'h3;
		compare_output_mode = 2'h3;
		force_compare = 1'b1;
		tk(1);
		force_compare = 1'b0;
		tk(2);
		chk("force pwm", 8'h00, {7'h0, compare_output});
		compare_output_mode = 2'h0;
	endtask

	// fast pwm: buffered compare loads at bottom only
	task automatic t_pwm();
		overflow_irq_enable = 1'b0;
		compare_irq_enable = 1'b0;
		compare_output_mode = 2'h2;
		waveform_mode_field = 2'h0;
		wcmp(8'h10);
		waveform_mode_field = 2'h3;
		wcmp(8'h30);
		chk("buf rd", 8'h30, compare_value);
		wcnt(8'h0e);
		clr(2'h3);
		clock_select_field = 3'h1;
		waitc(8'h12);
		chk("old cmp", 8'h01, {7'h0, interrupt_flag_reg[1]});
		clr(2'h2);
		waitc(8'h00);
		chk("pwm ovf", 8'h01, {7'h0, interrupt_flag_reg[0]});
		chk("pwm set", 8'h01, {7'h0, compare_output});
		waitc(8'h12);
		chk("no old", 8'h00, {7'h0, interrupt_flag_reg[1]});
		chk("pwm hold", 8'h01, {7'h0, compare_output});
		chk("masked", 8'h00, {6'h0, overflow_irq, compare_irq});
		waitc(8'h32);
		chk("new cmp", 8'h01, {7'h0, interrupt_flag_reg[1]});
		chk("pwm clr", 8'h00, {7'h0, compare_output});
		clock_select_field = 3'h0;
	endtask

	// phase correct: clear going up, set going down, load at top
	task automatic t_phase();
		waveform_mode_field = 2'h0;
		compare_output_mode = 2'h3;
		force_compare = 1'b1;
		tk(1);
		force_compare = 1'b0;
		wcmp(8'h40);
		clr(2'h3);
		chk("flags w1c", 8'h00, {6'h0, interrupt_flag_reg});
		chk("preset out", 8'h01, {7'h0, compare_output});
		waveform_mode_field = 2'h1;
		compare_output_mode = 2'h2;
		wcmp(8'hc0);
		chk("phase rd", 8'hc0, compare_value);
		wcnt(8'h3e);
		clock_select_field = 3'h1;
		waitc(8'h42);
		chk("up clear", 8'h00, {7'h0, compare_output});
		waitc(8'hff);
		waitc(8'hbe);
		chk("top load", 8'h01, {7'h0, compare_output});
		chk("top ovf", 8'h00, {7'h0, interrupt_flag_reg[0]});
		waitc(8'h00);
		tk(1);
		chk("turn up", 8'h01, counter_value);
		chk("bot ovf", 8'h01, {7'h0, interrupt_flag_reg[0]});
		clock_select_field = 3'h0;
		compare_output_mode = 2'h0;
		waveform_mode_field = 2'h0;
	endtask

	// every divisor but 1: ticks seen in 1024 clocks
	task automatic t_presc();
		logic [7:0] ex [6] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
		waveform_mode_field = 2'h0;
		for (int i = 0; i < 6; i++)
		begin
			clock_select_field = 3'(i + 2);
			wcnt(8'h00);
			tk(1024);
			chk("divided", ex[i], counter_value);
		end
		clock_select_field = 3'h0;
	endtask

	// crystal edges as the tick source
	task automatic t_xtal();
		waveform_mode_field = 2'h0;
		wcnt(8'h00);
		async_clock_select = 1'b1;
		clock_select_field = 3'h1;
		tk(20);
		chk("xtal idle", 8'h00, counter_value);
		repeat (4)
		begin
			crystal_pin_in = 1'b1;
			tk(5);
			crystal_pin_in = 1'b0;
			tk(5);
		end
		tk(5);
		chk("xtal cnt", 8'h04, counter_value);
		chk("xtal out", 8'h01, {7'h0, crystal_pin_out});
	endtask

	// main sequence
	initial
	begin
		{rst, cnt_wr, cmp_wr, flag_clear_wr, force_compare} = 5'h1f;
		{cnt_wr, cmp_wr, flag_clear_wr, force_compare} = 4'h0;
		{overflow_irq_ack, compare_irq_ack, async_clock_select, crystal_pin_in} = 4'h0;
		{overflow_irq_enable, compare_irq_enable} = 2'h0;
		{cnt_wdata, cmp_wdata} = 16'h0000;
		{waveform_mode_field, compare_output_mode, flag_clear_data} = 6'h00;
		clock_select_field = 3'h0;
		miscompares = 0;
		checks = 0;
		tk(3);
		chk("rst cnt", 8'h00, counter_value);
		chk("rst outs", 8'h00, {2'h0, overflow_irq, compare_irq, crystal_pin_out,
			compare_output, interrupt_flag_reg});
		rst = 1'b0;
		t_normal();
		t_compare();
		t_block();
		t_ctc();
		t_force();
		t_pwm();
		t_phase();
		t_presc();
		t_xtal();
		results();
	end
endmodule
`default_nettype wire
